//--- fbtep_pkg.sv
// Constants shared by the bank-two program/erase and protect logic
package fbtep_pkg;
	// Register map
	localparam logic [15:0] CTRL_ADDR = 16'hfe08;
	localparam logic [15:0] PROT_ADDR = 16'hff81;
	localparam logic [15:0] STAT_ADDR = 16'hfe0a;
	// Control register field positions
	localparam int PGM_BIT = 0;
	localparam int ERASE_BIT = 1;
	localparam int MASS_BIT = 2;
	localparam int HIGH_VOLTAGE_ENABLE_BIT = 3;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// Status register field positions
	localparam int STANDBY_BIT = 0;
	localparam int TARGET_BIT = 1;
	localparam int REFUSED_BIT = 2;
	// Protect byte decoding
	localparam logic [7:0] PROT_OPEN = 8'hff;
	localparam int PROT_LSB = 7;
	localparam int PROT_MSB = 14;
	localparam logic [15:0] ARRAY_END = 16'h7fff;
	// Page and row organisation
	localparam int ROW_LSB = 6;
	localparam int PAGE_LSB = 7;
	localparam logic [15:0] ROW_BYTES = 16'h0040;
	localparam logic [15:0] PAGE_BYTES = 16'h0080;
	// User regions of the array
	localparam logic [15:0] REG0_LO = 16'h0462;
	localparam logic [15:0] REG0_HI = 16'h04ff;
	localparam logic [15:0] REG1_LO = 16'h0980;
	localparam logic [15:0] REG1_HI = 16'h1b7f;
	localparam logic [15:0] REG2_LO = 16'h1e20;
	localparam logic [15:0] REG2_HI = 16'h7fff;
	// Answer to unmapped reads
	localparam logic [7:0] UNMAPPED_DATA = 8'h00;
endpackage

//--- fbtep_prot_if.sv
// Address and protect-byte signals between the controller and its decoders
`timescale 1ns/1ps
interface fbtep_prot_if;
	logic [15:0] addr;
	logic [7:0] protect_byte;
	logic [15:0] start_addr;
	logic addr_protected;
	logic mass_blocked;
	logic in_array;
	modport chk (input addr, input protect_byte, output start_addr, output addr_protected, output mass_blocked);
	modport dec (input addr, output in_array);
	modport user (output addr, output protect_byte, input start_addr, input addr_protected, input mass_blocked,
		input in_array);
endinterface

//--- fbtep_prot_chk.sv
// Protect byte to start address and protected-range check
`timescale 1ns/1ps
module fbtep_prot_chk (
	// Decoder side
	fbtep_prot_if.chk ifc
);
	// Byte lands on address bits 14..7, others zero
	assign ifc.start_addr = {1'b0, ifc.protect_byte, {fbtep_pkg::PROT_LSB{1'b0}}};
	// Start up to last location; all ones leaves everything open
	assign ifc.addr_protected = (ifc.protect_byte != fbtep_pkg::PROT_OPEN) &&
		(ifc.addr >= ifc.start_addr) && (ifc.addr <= fbtep_pkg::ARRAY_END);
	assign ifc.mass_blocked = (ifc.protect_byte != fbtep_pkg::PROT_OPEN);
endmodule

//--- fbtep_region_dec.sv
// Decodes whether an address falls inside one of the three user regions
`timescale 1ns/1ps
module fbtep_region_dec (
	// Decoder side
	fbtep_prot_if.dec ifc
);
	// Array is not contiguous
	assign ifc.in_array = ((ifc.addr >= fbtep_pkg::REG0_LO) && (ifc.addr <= fbtep_pkg::REG0_HI)) ||
		((ifc.addr >= fbtep_pkg::REG1_LO) && (ifc.addr <= fbtep_pkg::REG1_HI)) ||
		((ifc.addr >= fbtep_pkg::REG2_LO) && (ifc.addr <= fbtep_pkg::REG2_HI));
endmodule

//--- fbtep_ctrl.sv
// Bank-two program/erase control with block protection and low-power standby
`timescale 1ns/1ps
// What this block does
// - Wait or stop during program/erase suspends it into standby.
// - In standby every control line to the array is inactive.
// - Erased cells read one, programmed cells read zero.
// - Pages of two 64-byte rows; erase per page, program per row.
// - Three user regions; control and protect registers at fixed addresses.
// - High-voltage enable sets only with program or erase and proper sequence.
// - Mass bit selects whole-array erase, else page erase; read/write.
// - Program and erase bits are never both one.
// - Protect byte lives in bank one, altered only by its sequence.
// - Protect byte is start address bits 14..7, other bits zero.
// - Protection runs from start address to end of array.
// - Each decrement adds one page; first step from all ones adds two.
// - All zeros protects everything; all ones protects nothing.
// - High voltage refused for targets inside the protected range.
// - Mass erase selected before the target write is blocked unless the protect byte is all ones.
// - Vector page erase also erases protect bytes unless bank one protects it.
module fbtep_ctrl (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Register bus
	input wire logic [15:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr_stb,
	input wire logic i_rd_stb,
	output logic [7:0] o_rdata,
	// Processor power modes
	input wire logic i_wait_mode,
	input wire logic i_stop_mode,
	// Protect byte held in bank one
	input wire logic [7:0] i_protect_byte,
	input wire logic i_bank_one_vector_erase,
	input wire logic i_bank_one_vector_protected,
	// Array side
	input wire logic [7:0] i_array_rdata,
	output logic o_pump_on,
	output logic o_hv_array,
	output logic o_erase_active,
	output logic o_mass_active,
	output logic o_prog_active,
	output logic [15:0] o_target_addr,
	output logic o_prog_stb,
	output logic [15:0] o_prog_addr,
	output logic [7:0] o_prog_data,
	output logic o_protect_bytes_erase
);
	typedef enum logic [2:0] {
		SEQ_IDLE,
		SEQ_SELECTED,
		SEQ_PROT_READ,
		SEQ_TARGET,
		SEQ_HV,
		SEQ_STANDBY
	} fbtep_seq_t;

	typedef struct packed {
		fbtep_seq_t seq;
		logic high_voltage_enable;
		logic mass;
		logic erase;
		logic program_select;
		logic refused;
		logic [15:0] target;
		logic prog_stb;
		logic [15:0] prog_addr;
		logic [7:0] prog_data;
		logic [7:0] rdata;
	} fbtep_state_t;

	fbtep_state_t st_reg;
	fbtep_state_t st_next;
	fbtep_prot_if ifc ();

	logic low_power;
	logic wr_ctrl;
	logic wr_stat;
	logic rd_prot;
	logic wr_array;
	logic active;
	logic target_ok;
	logic row_match;
	logic [7:0] ctrl_view;
	logic [7:0] stat_view;
	logic [15:0] page_base;
	logic [15:0] row_base;

	assign ifc.addr = i_addr;
	assign ifc.protect_byte = i_protect_byte;

	fbtep_prot_chk u_prot_chk (
		.ifc (ifc.chk)
	);

	fbtep_region_dec u_region_dec (
		.ifc (ifc.dec)
	);

	// Bus decode
	assign low_power = i_wait_mode | i_stop_mode;
	assign wr_ctrl = i_wr_stb && (i_addr == fbtep_pkg::CTRL_ADDR);
	assign wr_stat = i_wr_stb && (i_addr == fbtep_pkg::STAT_ADDR);
	assign rd_prot = i_rd_stb && (i_addr == fbtep_pkg::PROT_ADDR);
	assign wr_array = i_wr_stb && ifc.in_array;
	assign page_base = i_addr & ~(fbtep_pkg::PAGE_BYTES - 16'h0001);
	assign row_base = i_addr & ~(fbtep_pkg::ROW_BYTES - 16'h0001);
	assign row_match = (row_base == st_reg.target);
	// Whole-array erase checks the byte, otherwise the target address
	assign target_ok = (st_reg.erase && st_reg.mass) ? !ifc.mass_blocked : !ifc.addr_protected;

	always_comb begin
		ctrl_view = fbtep_pkg::CTRL_RESET;
		ctrl_view[fbtep_pkg::HIGH_VOLTAGE_ENABLE_BIT] = st_reg.high_voltage_enable;
		ctrl_view[fbtep_pkg::MASS_BIT] = st_reg.mass;
		ctrl_view[fbtep_pkg::ERASE_BIT] = st_reg.erase;
		ctrl_view[fbtep_pkg::PGM_BIT] = st_reg.program_select;
		stat_view = 8'h00;
		stat_view[fbtep_pkg::STANDBY_BIT] = (st_reg.seq == SEQ_STANDBY);
		stat_view[fbtep_pkg::TARGET_BIT] = (st_reg.seq == SEQ_TARGET) || (st_reg.seq == SEQ_HV);
		stat_view[fbtep_pkg::REFUSED_BIT] = st_reg.refused;
	end

	always_comb begin
		st_next = st_reg;
		st_next.prog_stb = 1'b0;
		st_next.rdata = fbtep_pkg::UNMAPPED_DATA;
		// Clear first so a refusal in the same cycle wins
		if (wr_stat && i_wdata[fbtep_pkg::REFUSED_BIT]) begin
			st_next.refused = 1'b0;
		end
		if (wr_ctrl) begin
			// Both requested together: keep the previous pair
			if (!(i_wdata[fbtep_pkg::PGM_BIT] && i_wdata[fbtep_pkg::ERASE_BIT])) begin
				st_next.program_select = i_wdata[fbtep_pkg::PGM_BIT];
				st_next.erase = i_wdata[fbtep_pkg::ERASE_BIT];
			end
			st_next.mass = i_wdata[fbtep_pkg::MASS_BIT];
			if (!i_wdata[fbtep_pkg::HIGH_VOLTAGE_ENABLE_BIT]) begin
				st_next.high_voltage_enable = 1'b0;
			end else if ((st_reg.seq == SEQ_TARGET) && (st_next.program_select || st_next.erase) && !low_power) begin
				st_next.high_voltage_enable = 1'b1;
			end
		end
		case (st_reg.seq)
			SEQ_IDLE: begin
				if (st_reg.program_select || st_reg.erase) begin
					st_next.seq = SEQ_SELECTED;
				end
			end
			SEQ_SELECTED: begin
				if (rd_prot) begin
					st_next.seq = SEQ_PROT_READ;
				end
			end
			SEQ_PROT_READ: begin
				if (wr_array) begin
					if (target_ok) begin
						// Erase latches the page, program the row
						st_next.target = st_reg.program_select ? row_base : page_base;
						st_next.seq = SEQ_TARGET;
					end else begin
						st_next.refused = 1'b1;
					end
				end
			end
			SEQ_TARGET: begin
				if (st_next.high_voltage_enable) begin
					st_next.seq = SEQ_HV;
				end
			end
			SEQ_HV: begin
				if (wr_array && st_reg.program_select && st_reg.high_voltage_enable) begin
					// A byte outside the latched row fails
					if (row_match) begin
						st_next.prog_stb = 1'b1;
						st_next.prog_addr = i_addr;
						st_next.prog_data = i_wdata;
					end else begin
						st_next.refused = 1'b1;
					end
				end
				if (!st_next.high_voltage_enable) begin
					st_next.seq = SEQ_IDLE;
				end
			end
			SEQ_STANDBY: begin
				if (!low_power) begin
					st_next.seq = SEQ_IDLE;
				end
			end
			default: begin
				st_next.seq = SEQ_IDLE;
			end
		endcase
		// Deselecting before high voltage abandons the sequence
		if (!st_next.program_select && !st_next.erase && !st_next.high_voltage_enable && (st_next.seq != SEQ_STANDBY)) begin
			st_next.seq = SEQ_IDLE;
		end
		// Wait or stop during an operation suspends it
		if (low_power && (st_reg.seq != SEQ_IDLE)) begin
			st_next.seq = SEQ_STANDBY;
			st_next.high_voltage_enable = 1'b0;
			st_next.prog_stb = 1'b0;
		end
		if (i_rd_stb) begin
			if (i_addr == fbtep_pkg::CTRL_ADDR) begin
				st_next.rdata = ctrl_view;
			end else if (i_addr == fbtep_pkg::STAT_ADDR) begin
				st_next.rdata = stat_view;
			end else if (i_addr == fbtep_pkg::PROT_ADDR) begin
				st_next.rdata = i_protect_byte;
			end else if (ifc.in_array) begin
				// Cells pass unchanged: erased one, programmed zero
				st_next.rdata = i_array_rdata;
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Array controls, all dropped in standby
	assign active = (st_reg.seq != SEQ_STANDBY) && !low_power;
	assign o_pump_on = st_reg.high_voltage_enable && active;
	assign o_hv_array = st_reg.high_voltage_enable && active;
	assign o_erase_active = st_reg.erase && active;
	assign o_mass_active = st_reg.erase && st_reg.mass && active;
	assign o_prog_active = st_reg.program_select && active;
	assign o_target_addr = st_reg.target;
	assign o_prog_stb = st_reg.prog_stb;
	assign o_prog_addr = st_reg.prog_addr;
	assign o_prog_data = st_reg.prog_data;
	assign o_rdata = st_reg.rdata;
	// Unprotected vector page erase wipes both protect bytes
	assign o_protect_bytes_erase = i_bank_one_vector_erase && !i_bank_one_vector_protected;

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);

	interlock_never_a: assert property (!(st_reg.program_select && st_reg.erase))
		else $error("program and erase both set");

	high_voltage_enable_cause_a: assert property ($rose(st_reg.high_voltage_enable) |-> $past(st_reg.seq) == SEQ_TARGET
		&& (st_reg.program_select || st_reg.erase))
		else $error("high voltage set outside the sequence");

	prot_refuse_a: assert property ((st_reg.seq == SEQ_PROT_READ) && wr_array && !st_reg.mass
		&& ifc.addr_protected |=> st_reg.seq == SEQ_PROT_READ && st_reg.refused)
		else $error("protected target accepted");

	mass_block_a: assert property ((st_reg.seq == SEQ_PROT_READ) && wr_array && st_reg.erase
		&& st_reg.mass && (i_protect_byte != fbtep_pkg::PROT_OPEN) |=> st_reg.seq != SEQ_TARGET)
		else $error("mass erase accepted with protection");

	suspend_a: assert property (low_power && (st_reg.seq != SEQ_IDLE) |=>
		st_reg.seq == SEQ_STANDBY && !st_reg.high_voltage_enable)
		else $error("operation not suspended");

	standby_quiet_a: assert property ((st_reg.seq == SEQ_STANDBY) |-> !o_pump_on && !o_hv_array
		&& !o_erase_active && !o_mass_active && !o_prog_active && !o_prog_stb)
		else $error("array control active in standby");

	start_addr_a: assert property (ifc.start_addr[fbtep_pkg::PROT_MSB:fbtep_pkg::PROT_LSB] == i_protect_byte
		&& ifc.start_addr[15] == 1'b0 && ifc.start_addr[fbtep_pkg::PROT_LSB-1:0] == '0)
		else $error("protect start address malformed");

	open_byte_a: assert property ((i_protect_byte == fbtep_pkg::PROT_OPEN) |-> !ifc.addr_protected
		&& !ifc.mass_blocked)
		else $error("open protect byte still protects");

	row_target_a: assert property ((st_reg.seq == SEQ_PROT_READ) && wr_array && target_ok && st_reg.program_select
		|=> st_reg.target[fbtep_pkg::ROW_LSB-1:0] == '0 && st_reg.seq == SEQ_TARGET)
		else $error("row target not aligned");

	ctrl_read_a: assert property (i_rd_stb && (i_addr == fbtep_pkg::CTRL_ADDR) |=>
		o_rdata[fbtep_pkg::MASS_BIT] == $past(st_next.mass))
		else $error("mass bit read back wrong");

	mass_erase_c: cover property (st_reg.erase && st_reg.mass && st_reg.seq == SEQ_HV);
	row_prog_c: cover property (o_prog_stb ##[1:20] o_prog_stb);
	suspend_c: cover property (st_reg.seq == SEQ_HV ##1 st_reg.seq == SEQ_STANDBY);
	refuse_c: cover property ($rose(st_reg.refused));
endmodule

//--- fbtep_ctrl_tb_top.sv
// Self-checking testbench for the bank-two program/erase controller
`timescale 1ns/1ps
module fbtep_ctrl_tb_top;
	logic i_core_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic wr_stb = 1'b0;
	logic rd_stb = 1'b0;
	logic [7:0] rdata;
	logic wait_mode = 1'b0;
	logic stop_mode = 1'b0;
	logic [7:0] prot_byte = 8'hff;
	logic vec_erase = 1'b0;
	logic vec_prot = 1'b0;
	logic [7:0] arr_rdata = 8'h00;
	logic pump_on, hv_array, erase_act, mass_act, prog_act, prog_stb, prot_erase;
	logic [15:0] target_addr, prog_addr;
	logic [7:0] prog_data;
	logic [7:0] d;
	int num_errors = 0;
	int n_checks = 0;
	int cycles = 0;
	// Sequence table: select bits, protect byte, array address, high voltage accepted
	logic [7:0] t_sel [8] = '{8'h02, 8'h02, 8'h06, 8'h06, 8'h02, 8'h02, 8'h02, 8'h01};
	logic [7:0] t_pb [8] = '{8'hfe, 8'hfe, 8'hfe, 8'hff, 8'h00, 8'h14, 8'h14, 8'hff};
	logic [15:0] t_a [8] = '{16'h7e80, 16'h7f00, 16'h1e20, 16'h1e20, 16'h0462, 16'h09ff, 16'h0a00, 16'h1e40};
	logic t_ok [8] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

	fbtep_ctrl i_fbtep_ctrl (
		.i_core_clk(i_core_clk),
		.i_rst_n(i_rst_n),
		.i_addr(addr),
		.i_wdata(wdata),
		.i_wr_stb(wr_stb),
		.i_rd_stb(rd_stb),
		.o_rdata(rdata),
		.i_wait_mode(wait_mode),
		.i_stop_mode(stop_mode),
		.i_protect_byte(prot_byte),
		.i_bank_one_vector_erase(vec_erase),
		.i_bank_one_vector_protected(vec_prot),
		.i_array_rdata(arr_rdata),
		.o_pump_on(pump_on),
		.o_hv_array(hv_array),
		.o_erase_active(erase_act),
		.o_mass_active(mass_act),
		.o_prog_active(prog_act),
		.o_target_addr(target_addr),
		.o_prog_stb(prog_stb),
		.o_prog_addr(prog_addr),
		.o_prog_data(prog_data),
		.o_protect_bytes_erase(prot_erase)
	);

	always #4 i_core_clk = ~i_core_clk;

	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Guards against a hang
	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			finish_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] v);
		@(posedge i_core_clk);
		addr <= a;
		wdata <= v;
		wr_stb <= 1'b1;
		@(posedge i_core_clk);
		wr_stb <= 1'b0;
	endtask

	// Read data is registered and stands one cycle only
	task automatic rd(input logic [15:0] a, output logic [7:0] v);
		@(posedge i_core_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge i_core_clk);
		rd_stb <= 1'b0;
		#1 v = rdata;
	endtask

	// Select, read protect byte, latch target, then ask for high voltage
	task automatic run_seq(input int i);
		logic [7:0] sel;
		sel = t_sel[i];
		@(posedge i_core_clk);
		prot_byte <= t_pb[i];
		wr(fbtep_pkg::CTRL_ADDR, sel);
		rd(fbtep_pkg::PROT_ADDR, d);
		check(d, t_pb[i]);
		wr(t_a[i], 8'h5a);
		wr(fbtep_pkg::CTRL_ADDR, sel | 8'h08);
		rd(fbtep_pkg::CTRL_ADDR, d);
		check(d, t_ok[i] ? (sel | 8'h08) : sel);
		check({pump_on, hv_array}, {t_ok[i], t_ok[i]});
		check({erase_act, mass_act, prog_act}, {sel[1], sel[1] & sel[2], sel[0]});
		if (t_ok[i] && !sel[2]) begin
			check(target_addr, sel[0] ? {t_a[i][15:6], 6'h00} : {t_a[i][15:7], 7'h00});
		end
		rd(fbtep_pkg::STAT_ADDR, d);
		check(d[2], !t_ok[i]);
	endtask

	initial begin
		repeat (4) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		rd(fbtep_pkg::CTRL_ADDR, d);
		check(d, fbtep_pkg::CTRL_RESET);
		check({pump_on, hv_array, erase_act, mass_act, prog_act, prog_stb}, 6'h00);
		rd(16'h0000, d);
		check(d, fbtep_pkg::UNMAPPED_DATA);
		wr(fbtep_pkg::CTRL_ADDR, 8'h08);
		rd(fbtep_pkg::CTRL_ADDR, d);
		check(d, 8'h00);
		wr(fbtep_pkg::CTRL_ADDR, 8'h03);
		rd(fbtep_pkg::CTRL_ADDR, d);
		check(d, 8'h00);
		wr(fbtep_pkg::CTRL_ADDR, 8'h04);
		rd(fbtep_pkg::CTRL_ADDR, d);
		check(d, 8'h04);
		wr(fbtep_pkg::CTRL_ADDR, 8'h01);
		wr(fbtep_pkg::CTRL_ADDR, 8'h03);
		wr(fbtep_pkg::CTRL_ADDR, 8'h09);
		rd(fbtep_pkg::CTRL_ADDR, d);
		check(d, 8'h01);
		wr(fbtep_pkg::CTRL_ADDR, 8'h00);
		for (int i = 0; i < 8; i++) begin
			run_seq(i);
			if (i == 0 || i == 3) begin
				@(posedge i_core_clk);
				wait_mode <= (i == 0);
				stop_mode <= (i == 3);
				#1 check({pump_on, hv_array, erase_act, mass_act, prog_act}, 5'h00);
				@(posedge i_core_clk);
				wait_mode <= 1'b0;
				stop_mode <= 1'b0;
				rd(fbtep_pkg::CTRL_ADDR, d);
				check(d, t_sel[i]);
			end
			if (i == 7) begin
				wr(16'h1e45, 8'ha7);
				#1 check({prog_stb, prog_addr, prog_data}, {1'b1, 16'h1e45, 8'ha7});
				wr(16'h1e85, 8'h11);
				#1 check(prog_stb, 1'b0);
				rd(fbtep_pkg::STAT_ADDR, d);
				check(d[2], 1'b1);
			end
			// Select bits drop first, high voltage after
			wr(fbtep_pkg::CTRL_ADDR, 8'h08);
			wr(fbtep_pkg::CTRL_ADDR, 8'h00);
			wr(fbtep_pkg::STAT_ADDR, 8'h04);
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge i_core_clk);
			arr_rdata <= k ? 8'h00 : 8'hff;
			rd(16'h1e20, d);
			check(d, k ? 8'h00 : 8'hff);
		end
		for (int k = 0; k < 4; k++) begin
			@(posedge i_core_clk);
			{vec_erase, vec_prot} <= k[1:0];
			#1 check(prot_erase, k == 2);
		end
		finish_test();
	end
endmodule
